// ===== rtl/licr_pkg.sv
// Functional notes
// (R1) two-bit field picks one of four terminations
// (R2) termination mode sets transmit level code
// (R3) ringer bit: clear high, set synthesized
// (R4) threshold bit picks ring detection window
// (R5) second register resets zero, bits 6:0 writable
// (R6) writing one to bit 6 starts calibration
// (R7) bit 5 set suppresses automatic calibration
// (R8) software writes zero to reserved bit 7
package licr_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] LICR_FIRST_OFFSET = 12'h000;
  localparam logic [11:0] LICR_SECOND_OFFSET = 12'h004;
  localparam logic [7:0] LICR_FIRST_RESET = 8'h00;
  localparam logic [7:0] LICR_SECOND_RESET = 8'h00;
  localparam logic [7:0] LICR_SECOND_WMASK = 8'h7F;

  // ==========================================================
  // field positions
  localparam int LICR_TERM_LSB = 2;
  localparam int LICR_RING_IMP_BIT = 1;
  localparam int LICR_RING_THR_BIT = 0;
  localparam int LICR_MANUAL_CAL_START_BIT = 6;
  localparam int LICR_AUTO_CAL_DISABLE_BIT = 5;

  // ==========================================================
  // termination modes and transmit level codes
  typedef enum logic [1:0] {
    LICR_TERM_LOW_VOLTAGE = 2'h0,
    LICR_TERM_REGIONAL_LOW = 2'h1,
    LICR_TERM_STANDARD = 2'h2,
    LICR_TERM_CURRENT_LIMIT = 2'h3
  } licr_term_e;

  // signed dBm
  localparam logic signed [3:0] LICR_TX_LEVEL_M5 = -4'sd5;
  localparam logic signed [3:0] LICR_TX_LEVEL_M3 = -4'sd3;
  localparam logic signed [3:0] LICR_TX_LEVEL_M1 = -4'sd1;

  typedef struct packed {
    licr_term_e termination_mode_sel;
    logic signed [3:0] tx_level_dbm;
    logic ringer_impedance_sel;
    logic ring_threshold_sel;
    logic auto_cal_disable;
  } licr_line_ctrl_s;

  function automatic logic signed [3:0] licr_tx_level(input licr_term_e mode);
    case (mode)
      LICR_TERM_LOW_VOLTAGE: licr_tx_level = LICR_TX_LEVEL_M5;
      LICR_TERM_REGIONAL_LOW: licr_tx_level = LICR_TX_LEVEL_M3;
      default: licr_tx_level = LICR_TX_LEVEL_M1;
    endcase
  endfunction

endpackage

// ===== rtl/licr_line_interface_control_regs.sv
`timescale 1ns/10ps
module licr_line_interface_control_regs
  import licr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output licr_line_ctrl_s line_ctrl_out,
  output logic cal_start_out
);

  // ==========================================================
  // register storage
  logic [7:0] first_reg;
  logic [7:0] second_reg;
  logic [7:0] next_first_reg;
  logic [7:0] next_second_reg;

  // ==========================================================
  // bus phase and decode
  logic setup_ok;
  logic access_ok;
  logic hit_first;
  logic hit_second;
  logic mapped;
  logic wr_first;
  logic wr_second;
  logic [31:0] next_prdata;

  // ==========================================================
  // line settings held for the analog side
  licr_term_e term_mode;
  licr_term_e next_term_mode;
  logic signed [3:0] tx_level;
  logic signed [3:0] next_tx_level;
  logic ringer_imp;
  logic ring_thr;
  logic cal_disable;

  // ==========================================================
  // word match against one register offset
  function automatic logic licr_addr_hit(
    input logic [11:0] addr,
    input logic [11:0] offset
  );
    licr_addr_hit = (addr == offset);
  endfunction

  // ==========================================================
  // merge of written bits under a mask
  function automatic logic [7:0] licr_masked(
    input logic [7:0] old_value,
    input logic [7:0] new_value,
    input logic [7:0] mask
  );
    licr_masked = (old_value & ~mask) | (new_value & mask);
  endfunction

  // ==========================================================
  // address decode
  always_comb
  begin
    hit_first = 1'b0;
    hit_second = 1'b0;
    if (licr_addr_hit(paddr_in, LICR_FIRST_OFFSET))
    begin
      hit_first = 1'b1;
    end
    else if (licr_addr_hit(paddr_in, LICR_SECOND_OFFSET))
    begin
      hit_second = 1'b1;
    end
  end

  assign mapped = hit_first || hit_second;

  // ==========================================================
  // bus phases, writes land only at the pready edge
  assign setup_ok = psel_in && !penable_in;
  assign access_ok = psel_in && penable_in && pready_out;
  assign wr_first = access_ok && pwrite_in && hit_first;
  assign wr_second = access_ok && pwrite_in && hit_second;

  // ==========================================================
  // read data select, launched in setup
  always_comb
  begin
    next_prdata = prdata_out;
    if (setup_ok && !pwrite_in)
    begin
      if (hit_first)
      begin
        next_prdata = {24'h00_0000, first_reg};
      end
      else if (hit_second)
      begin
        next_prdata = {24'h00_0000, second_reg};
      end
      else
      begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // next register values
  always_comb
  begin
    next_first_reg = first_reg;
    if (wr_first)
    begin
      next_first_reg = pwdata_in[7:0];
    end
  end

  always_comb
  begin
    next_second_reg = second_reg;
    if (wr_second)
    begin
      next_second_reg = licr_masked(second_reg, pwdata_in[7:0], LICR_SECOND_WMASK); // R5
    end
  end

  // ==========================================================
  // line setting decode
  always_comb
  begin
    next_term_mode = licr_term_e'(first_reg[LICR_TERM_LSB +: 2]); // R1
    next_tx_level = licr_tx_level(next_term_mode); // R2
  end

  // ==========================================================
  // ready, no wait state
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      pready_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      pready_out <= setup_ok;
    end
  end

  // ==========================================================
  // error for unmapped words
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      pslverr_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      pslverr_out <= setup_ok && !mapped;
    end
  end

  // ==========================================================
  // read data
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      prdata_out <= 32'h0000_0000;
    end
    else if (clk_en_in)
    begin
      prdata_out <= next_prdata;
    end
  end

  // ==========================================================
  // first register
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      first_reg <= LICR_FIRST_RESET;
    end
    else if (clk_en_in)
    begin
      first_reg <= next_first_reg;
    end
  end

  // ==========================================================
  // second register, bit 7 reads zero
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      second_reg <= LICR_SECOND_RESET; // R5
    end
    else if (clk_en_in)
    begin
      second_reg <= next_second_reg; // R5
    end
  end

  // ==========================================================
  // termination mode
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      term_mode <= LICR_TERM_LOW_VOLTAGE;
    end
    else if (clk_en_in)
    begin
      term_mode <= next_term_mode; // R1
    end
  end

  // ==========================================================
  // transmit level
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      tx_level <= 4'sh0;
    end
    else if (clk_en_in)
    begin
      tx_level <= next_tx_level; // R2
    end
  end

  // ==========================================================
  // ringer impedance
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      ringer_imp <= 1'b0;
    end
    else if (clk_en_in)
    begin
      ringer_imp <= first_reg[LICR_RING_IMP_BIT]; // R3
    end
  end

  // ==========================================================
  // ring threshold window
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      ring_thr <= 1'b0;
    end
    else if (clk_en_in)
    begin
      ring_thr <= first_reg[LICR_RING_THR_BIT]; // R4
    end
  end

  // ==========================================================
  // automatic calibration disable
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      cal_disable <= 1'b0;
    end
    else if (clk_en_in)
    begin
      cal_disable <= second_reg[LICR_AUTO_CAL_DISABLE_BIT]; // R7
    end
  end

  // ==========================================================
  // manual calibration start pulse
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      cal_start_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      cal_start_out <= wr_second && pwdata_in[LICR_MANUAL_CAL_START_BIT]; // R6
    end
  end

  // ==========================================================
  // line settings out, all from flops
  assign line_ctrl_out = {
    term_mode,
    tx_level,
    ringer_imp,
    ring_thr,
    cal_disable
  };

endmodule // licr_line_interface_control_regs

// ===== tb/licr_asserts.sv
`timescale 1ns/10ps
module licr_asserts
  import licr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire licr_line_ctrl_s line_ctrl_out,
  input wire logic cal_start_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  licr_line_ctrl_s c;
  assign c = line_ctrl_out;
  sequence s_setup;
    clk_en_in && psel_in && !penable_in;
  endsequence
  sequence s_wr_first;
    clk_en_in && psel_in && !penable_in && pwrite_in && paddr_in == LICR_FIRST_OFFSET;
  endsequence
  sequence s_wr_second;
    clk_en_in && psel_in && !penable_in && pwrite_in && paddr_in == LICR_SECOND_OFFSET;
  endsequence
  sequence s_rd_second;
    clk_en_in && psel_in && !penable_in && !pwrite_in && paddr_in == LICR_SECOND_OFFSET;
  endsequence
  // write lands at access edge, line flops one edge later
  property p_first;
    s_wr_first |-> ##3
      ({c.termination_mode_sel, c.ringer_impedance_sel, c.ring_threshold_sel}
        == $past(pwdata_in[3:0], 3))
      && c.tx_level_dbm == (c.termination_mode_sel == LICR_TERM_LOW_VOLTAGE ? LICR_TX_LEVEL_M5
        : c.termination_mode_sel == LICR_TERM_REGIONAL_LOW ? LICR_TX_LEVEL_M3
        : LICR_TX_LEVEL_M1);
  endproperty
  a_first: assert property (p_first) else $error("first register settings");
  property p_cal;
    s_wr_second |-> ##2 (cal_start_out == $past(pwdata_in[LICR_MANUAL_CAL_START_BIT], 2))
      ##1 (c.auto_cal_disable == $past(pwdata_in[LICR_AUTO_CAL_DISABLE_BIT], 3));
  endproperty
  a_cal: assert property (p_cal) else $error("calibration controls");
  property p_cal_pulse;
    cal_start_out && clk_en_in |=> !cal_start_out;
  endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("calibration pulse width");
  property p_ready;
    s_setup |=> pready_out;
  endproperty
  a_ready: assert property (p_ready) else $error("ready after setup");
  property p_ready_pulse;
    pready_out && clk_en_in |=> !pready_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready width");
  property p_err;
    pslverr_out |-> pready_out;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rd_second;
    s_rd_second |=> prdata_out[7] == 1'b0;
  endproperty
  a_rd_second: assert property (p_rd_second) else $error("reserved bit read");
endmodule // licr_asserts

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import licr_pkg::*;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic pready_out;
  logic pslverr_out;
  logic cal_start_out;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic [31:0] rd;
  logic err;
  licr_line_ctrl_s line_ctrl_out;
  int miscompares;
  int checked;
  int cyc;
  licr_line_interface_control_regs u_dut (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .line_ctrl_out(line_ctrl_out),
    .cal_start_out(cal_start_out)
  );
  initial forever #10 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    if (++cyc > 999)
    begin
      miscompares++;
      final_report;
    end
  end
  // setup, then access until pready, answer taken at that edge
  task apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h00_0000, v};
    @(posedge clock_in);
    penable_in <= 1'b1;
    do
      @(posedge clock_in);
    while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    penable_in <= 1'b0;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  task final_report;
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1;
    @(posedge clock_in);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, LICR_FIRST_OFFSET, {4'h0, i[1:0], i[0], !i[0]});
      apb(1'b0, LICR_FIRST_OFFSET, 8'h00);
      chk("first", {28'h000_0000, i[1:0], i[0], !i[0]}, rd);
      chk("line", {23'h00_0000, i[1:0],
        (i == 0 ? LICR_TX_LEVEL_M5 : i == 1 ? LICR_TX_LEVEL_M3 : LICR_TX_LEVEL_M1),
        i[0], !i[0], 1'b0}, {23'h00_0000, line_ctrl_out});
    end
    apb(1'b1, LICR_SECOND_OFFSET, 8'h7F);
    psel_in <= 1'b0;
    @(posedge clock_in);
    chk("cal_start", 32'h0000_0001, {31'h0000_0000, cal_start_out});
    apb(1'b0, LICR_SECOND_OFFSET, 8'h00);
    chk("second", 32'h0000_007F, rd);
    chk("cal_disable", 32'h0000_0001, {31'h0000_0000, line_ctrl_out.auto_cal_disable});
    apb(1'b0, 12'h008, 8'h00);
    chk("unmapped", 32'h0000_0000, rd);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
    clk_en_in <= 1'b0;
    pwrite_in <= 1'b1;
    paddr_in <= LICR_FIRST_OFFSET;
    pwdata_in <= 32'h0000_0000;
    repeat (3) @(posedge clock_in);
    chk("frozen_ready", 32'h0000_0000, {31'h0000_0000, pready_out});
    psel_in <= 1'b0;
    clk_en_in <= 1'b1;
    @(posedge clock_in);
    apb(1'b0, LICR_FIRST_OFFSET, 8'h00);
    chk("frozen_first", 32'h0000_000E, rd);
    psel_in <= 1'b0;
    rst_b_in <= 1'b0;
    @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    apb(1'b0, LICR_SECOND_OFFSET, 8'h00);
    chk("reset_second", {24'h00_0000, LICR_SECOND_RESET}, rd);
    apb(1'b0, LICR_FIRST_OFFSET, 8'h00);
    chk("reset_first", {24'h00_0000, LICR_FIRST_RESET}, rd);
    psel_in <= 1'b0;
    @(posedge clock_in);
    final_report;
  end
endmodule // tb_top
bind licr_line_interface_control_regs licr_asserts u_chk (
  .clock_in(clock_in),
  .rst_b_in(rst_b_in),
  .clk_en_in(clk_en_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .prdata_out(prdata_out),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .line_ctrl_out(line_ctrl_out),
  .cal_start_out(cal_start_out)
);
